// ==== logic/rxecr_pkg.sv ====
package rxecr_pkg;

  // ---------------------------------------------------------------
  // Register offsets, valid in bank 1 only.
  // ---------------------------------------------------------------
  localparam logic [6:0] OFS_EXT_RX_STATUS  = 7'h2e;
  localparam logic [6:0] OFS_FILTER_CAL     = 7'h2f;
  localparam logic [6:0] OFS_IQ_CAL_CONTROL = 7'h30;
  localparam logic [6:0] OFS_EXPERT_PLL     = 7'h31;
  localparam logic [1:0] BANK_EXTENDED      = 2'h1;

  // ---------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------
  localparam int BIT_HIGH_GAIN  = 7;
  localparam int BIT_BY_READ    = 6;
  localparam int BIT_IQ_ACTIVE  = 7;
  localparam int BIT_RC_ACTIVE  = 6;
  localparam int BIT_IQ_LAUNCH  = 7;
  localparam int BIT_SWING_RED  = 7;
  localparam int BIT_PD_WIDEN   = 6;
  localparam int BIT_SETTLE_FST = 5;

  // ---------------------------------------------------------------
  // Reset values.
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_EXPERT_PLL = 8'h04;
  localparam logic [6:0] RST_IQ_VALUE   = 7'h00;

  // ---------------------------------------------------------------
  // Timing of the settle counter, in 40 ns cycles.
  // ---------------------------------------------------------------
  localparam logic [7:0] SETTLE_FULL_CYC  = 8'h80;
  localparam logic [7:0] SETTLE_SHORT_CYC = 8'h20;

  // Receive sub-command codes.
  typedef enum logic [1:0] {
    RXECR_CMD_IDLE     = 2'b00,
    RXECR_CMD_WAKEUP   = 2'b01,
    RXECR_CMD_PREAMBLE = 2'b10,
    RXECR_CMD_DATA     = 2'b11
  } rxecr_cmd_t;

  // I/Q calibration sequence states, Gray from idle through run to done; the return to idle flips both bits.
  typedef enum logic [1:0] {
    RXECR_IQ_IDLE = 2'b00,
    RXECR_IQ_RUN  = 2'b01,
    RXECR_IQ_DONE = 2'b11
  } rxecr_iq_t;

endpackage

// ==== logic/rxecr_settle.sv ====
// Declares the channel filter settled a fixed time after an input transient.
module rxecr_settle (
  input  wire logic clk,          // Device clock.
  input  wire logic rst_n,        // Synchronous reset, active low.
  input  wire logic transient,    // Input transient pulse.
  input  wire logic fast,         // Shorter settle delay selected.
  output logic      settled       // Filter declared settled.
);

  logic [7:0] cnt_ff;
  logic       settled_ff;

  // Load the chosen delay on a transient and count it down.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff     <= 8'h00;
      settled_ff <= 1'b1;
    end else if (transient) begin
      cnt_ff     <= fast ? rxecr_pkg::SETTLE_SHORT_CYC : rxecr_pkg::SETTLE_FULL_CYC;
      settled_ff <= 1'b0;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff     <= cnt_ff - 8'h01;
      settled_ff <= (cnt_ff == 8'h01);
    end
  end

  assign settled = settled_ff;

endmodule

// ==== logic/rxecr_regs.sv ====
// How it works
// - Registers 2Eh to 31h respond only while bank 1 is selected.
// - Status bit 7 shows high gain active, one, or low gain, zero.
// - Status bit 6 is one for snapshot by read, zero for automatic.
// - Status bits 5:4 hold the receive sub-command at snapshot.
// - Status bits 3:0 hold the chip transition count at snapshot.
// - Calibration bit 7 is one while I/Q calibration runs.
// - Calibration bit 6 is one while RC calibration runs.
// - Calibration bits 3:0 hold last RC result; bits 5:4 read zero.
// - Writing one to I/Q bit 7 launches calibration; resets to zero.
// - Swing reduce bit is set automatically in the lower band.
// - Expert bit 6 widens the phase detector reset pulse.
// - Expert bit 5 selects the short filter settle delay.
// - Expert bits 4:0 set charge pump current; reset value four.
module rxecr_regs (
  input  wire logic       clk,            // Device clock.
  input  wire logic       rst_n,          // Synchronous reset, active low.
  input  wire logic [1:0] bank_sel,       // Selected register bank.
  input  wire logic [6:0] reg_addr,       // Register offset.
  input  wire logic       reg_wr,         // Write strobe.
  input  wire logic       reg_rd,         // Read strobe.
  input  wire logic [7:0] reg_wdata,      // Write data.
  output logic      [7:0] reg_rdata,      // Read data, registered.
  input  wire logic       high_gain,      // Receiver high gain active.
  input  wire logic [1:0] rx_cmd,         // Current receive sub-command.
  input  wire logic [3:0] chip_changes,   // Transition count in a chip.
  input  wire logic       search_done,    // Wakeup search or preamble done pulse.
  input  wire logic       status_read,    // Read of a receiver status register.
  input  wire logic       rc_cal_busy,    // RC calibration executing.
  input  wire logic [3:0] rc_cal_res,     // RC calibration result.
  input  wire logic       iq_cal_done,    // I/Q calibration finished pulse.
  input  wire logic [6:0] iq_cal_res,     // New I/Q calibration result.
  input  wire logic       lower_band,     // Lower frequency band in use.
  input  wire logic       transient,      // Channel filter input transient.
  output logic            iq_cal_start,   // Starts the I/Q sequence, pulse.
  output logic [6:0]      quadrature_cal_value, // Applied I/Q trim.
  output logic            oscillator_swing_reduce,    // Low oscillator drive.
  output logic            phase_detector_pulse_widen, // Long reset pulse.
  output logic            filter_settle_shortcut,     // Short settle delay.
  output logic [4:0]      charge_pump_current_sel,    // Current in 15 uA steps.
  output logic            filter_settled  // Channel filter settled.
);

  // ---------------------------------------------------------------
  // Access decode.
  // ---------------------------------------------------------------
  logic       in_bank;
  logic       wr_iq;
  logic       wr_exp;
  rxecr_pkg::rxecr_iq_t iq_st_ff;
  logic [7:0] snap_ff;
  logic [6:0] iq_val_ff;
  logic       iq_launch_ff;
  logic       start_ff;
  logic [7:0] expert_ff;
  logic       swing_ff;
  logic [3:0] rc_res_ff;
  logic       rc_busy_ff;
  logic [7:0] rdata_ff;
  logic       settled_w;
  logic [7:0] snap_word;
  logic [7:0] cal_word;

  assign in_bank = (bank_sel == rxecr_pkg::BANK_EXTENDED);
  assign wr_iq   = reg_wr && in_bank && (reg_addr == rxecr_pkg::OFS_IQ_CAL_CONTROL);
  assign wr_exp  = reg_wr && in_bank && (reg_addr == rxecr_pkg::OFS_EXPERT_PLL);

  // ---------------------------------------------------------------
  // Status snapshot.
  // ---------------------------------------------------------------

  // Assemble the snapshot word, each field at its own position.
  always_comb begin
    snap_word                           = 8'h00;
    snap_word[rxecr_pkg::BIT_HIGH_GAIN] = high_gain;
    snap_word[rxecr_pkg::BIT_BY_READ]   = status_read;
    snap_word[5:4]                      = rx_cmd;
    snap_word[3:0]                      = chip_changes;
  end

  // Capture gain, source, command and count together; read wins a tie.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      snap_ff <= 8'h00;
    end else if (status_read || search_done) begin
      snap_ff <= snap_word;
    end
  end

  // ---------------------------------------------------------------
  // RC calibration status.
  // ---------------------------------------------------------------

  // RC calibration state follows the analog block.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rc_busy_ff <= 1'b0;
      rc_res_ff  <= 4'h0;
    end else begin
      rc_busy_ff <= rc_cal_busy;
      rc_res_ff  <= rc_cal_res;
    end
  end

  // Calibration status word; the gap at bits 5:4 always reads zero.
  always_comb begin
    cal_word                           = 8'h00;
    cal_word[rxecr_pkg::BIT_IQ_ACTIVE] = iq_launch_ff;
    cal_word[rxecr_pkg::BIT_RC_ACTIVE] = rc_busy_ff;
    cal_word[3:0]                      = rc_res_ff;
  end

  // ---------------------------------------------------------------
  // I/Q calibration sequence.
  // ---------------------------------------------------------------

  // Launch on a written one, run until the done pulse, then retire.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      iq_st_ff     <= rxecr_pkg::RXECR_IQ_IDLE;
      iq_launch_ff <= 1'b0;
      start_ff     <= 1'b0;
      iq_val_ff    <= rxecr_pkg::RST_IQ_VALUE;
    end else begin
      start_ff <= 1'b0;
      case (iq_st_ff)
        rxecr_pkg::RXECR_IQ_IDLE: begin
          if (wr_iq) begin
            iq_val_ff <= reg_wdata[6:0];
            if (reg_wdata[rxecr_pkg::BIT_IQ_LAUNCH]) begin
              iq_launch_ff <= 1'b1;
              start_ff     <= 1'b1;
              iq_st_ff     <= rxecr_pkg::RXECR_IQ_RUN;
            end
          end
        end
        rxecr_pkg::RXECR_IQ_RUN: begin
          if (iq_cal_done) begin
            iq_val_ff <= iq_cal_res;
            iq_st_ff  <= rxecr_pkg::RXECR_IQ_DONE;
          end
        end
        rxecr_pkg::RXECR_IQ_DONE: begin
          iq_launch_ff <= 1'b0;
          iq_st_ff     <= rxecr_pkg::RXECR_IQ_IDLE;
        end
        default: begin
          iq_st_ff <= rxecr_pkg::RXECR_IQ_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Expert control.
  // ---------------------------------------------------------------

  // Software-written expert bits; reset leaves charge pump at four.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      expert_ff <= rxecr_pkg::RST_EXPERT_PLL;
    end else if (wr_exp) begin
      expert_ff <= reg_wdata;
    end
  end

  // Swing reduce is forced in the lower band, else follows software.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      swing_ff <= 1'b0;
    end else begin
      swing_ff <= lower_band || expert_ff[rxecr_pkg::BIT_SWING_RED];
    end
  end

  // ---------------------------------------------------------------
  // Channel filter settle timer.
  // ---------------------------------------------------------------

  // Bit 5 of the expert register trades settling accuracy for speed.
  rxecr_settle u_settle (
    .clk       (clk),
    .rst_n     (rst_n),
    .transient (transient),
    .fast      (expert_ff[rxecr_pkg::BIT_SETTLE_FST]),
    .settled   (settled_w)
  );

  // ---------------------------------------------------------------
  // Read path.
  // ---------------------------------------------------------------

  // Registered read data; other banks and offsets read zero.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd && in_bank) begin
      if (reg_addr == rxecr_pkg::OFS_EXT_RX_STATUS) begin
        rdata_ff <= snap_ff;
      end else if (reg_addr == rxecr_pkg::OFS_FILTER_CAL) begin
        rdata_ff <= cal_word;
      end else if (reg_addr == rxecr_pkg::OFS_IQ_CAL_CONTROL) begin
        rdata_ff <= {iq_launch_ff, iq_val_ff};
      end else if (reg_addr == rxecr_pkg::OFS_EXPERT_PLL) begin
        rdata_ff <= {swing_ff, expert_ff[6:0]};
      end else begin
        rdata_ff <= 8'h00;
      end
    end else if (reg_rd) begin
      rdata_ff <= 8'h00;
    end
  end

  // Outputs straight from flip-flops.
  assign reg_rdata                  = rdata_ff;
  assign iq_cal_start               = start_ff;
  assign quadrature_cal_value       = iq_val_ff;
  assign oscillator_swing_reduce    = swing_ff;
  assign phase_detector_pulse_widen = expert_ff[rxecr_pkg::BIT_PD_WIDEN];
  assign filter_settle_shortcut     = expert_ff[rxecr_pkg::BIT_SETTLE_FST];
  assign charge_pump_current_sel    = expert_ff[4:0];
  assign filter_settled             = settled_w;

endmodule

// ==== bench/rxecr_mcu_model.sv ====
// Host controller model: one strobed register access at a time.
module rxecr_mcu_model (
  input  wire logic [7:0] reg_rdata,  // Read data.
  input  wire logic       clk,        // Clock.
  output logic      [1:0] bank_sel,   // Bank.
  output logic      [6:0] reg_addr,   // Offset.
  output logic            reg_wr,     // Write strobe.
  output logic            reg_rd,     // Read strobe.
  output logic      [7:0] reg_wdata   // Write data.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] saved_trim;  // Trim kept by software.
  logic [7:0] dummy;       // Read data sink; save_trim takes the trim from it.
  // Bus idles in bank 1 with both strobes low.
  initial begin
    {bank_sel, reg_addr, reg_wr, reg_rd, reg_wdata} = {2'h1, 7'h00, 2'b00, 8'h00};
  end
  // Strobe held for one edge; read data is taken one cycle later.
  task automatic access(input logic rd, input logic [1:0] bank, input logic [6:0] addr,
                        input logic [7:0] wdata, output logic [7:0] rdata);
    @(posedge clk);
    {bank_sel, reg_addr, reg_wdata, reg_wr, reg_rd} <= {bank, addr, wdata, !rd, rd};
    @(posedge clk);
    {reg_wr, reg_rd, reg_wdata} <= {2'b00, ~wdata};  // Released data does not linger.
    @(posedge clk);
    rdata = reg_rdata;
  endtask
  // Keeps the device trim for later restore.
  task automatic save_trim();
    access(1'b1, 2'h1, 7'h30, 8'h00, dummy);
    saved_trim = dummy[6:0];
  endtask
  // Writes the kept trim back without launching.
  task automatic restore_trim();
    access(1'b0, 2'h1, 7'h30, {1'b0, saved_trim}, dummy);
  endtask
  // Returns expert settings to their reset values.
  task automatic expert_defaults();
    access(1'b0, 2'h1, 7'h31, 8'h04, dummy);
  endtask
endmodule

// ==== bench/rxecr_assertions.sv ====
// Port checker for the extended receive status register bank.
module rxecr_assertions (
  input wire logic       clk,                         // Clock.
  input wire logic       rst_n,                       // Reset.
  input wire logic [1:0] bank_sel,                    // Bank.
  input wire logic [6:0] reg_addr,                    // Offset.
  input wire logic       reg_wr,                      // Write.
  input wire logic       reg_rd,                      // Read.
  input wire logic [7:0] reg_wdata,                   // Write data.
  input wire logic [7:0] reg_rdata,                   // Read data.
  input wire logic       lower_band,                  // Low band.
  input wire logic       transient,                   // Transient.
  input wire logic       iq_cal_start,                // Launch pulse.
  input wire logic       oscillator_swing_reduce,     // Swing.
  input wire logic       phase_detector_pulse_widen,  // Widen.
  input wire logic       filter_settle_shortcut,      // Short settle.
  input wire logic [4:0] charge_pump_current_sel,     // Pump.
  input wire logic       filter_settled               // Settled.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  other_bank_rd_a: assert property (reg_rd && bank_sel != 2'h1 |=> reg_rdata == 8'h00)
    else $error("read outside bank 1 returned data");
  other_bank_wr_a: assert property (reg_wr && bank_sel != 2'h1 |=> $stable(charge_pump_current_sel))
    else $error("write outside bank 1 took effect");
  cal_zero_a: assert property (reg_rd && bank_sel == 2'h1 && reg_addr == 7'h2f |=> reg_rdata[5:4] == 2'b00)
    else $error("calibration bits 5:4 not zero");
  launch_cause_a: assert property (iq_cal_start |-> $past(reg_wr && bank_sel == 2'h1 && reg_addr == 7'h30 && reg_wdata[7]))
    else $error("launch without launching write");
  launch_pulse_a: assert property (iq_cal_start |=> !iq_cal_start)
    else $error("launch longer than one cycle");
  swing_auto_a: assert property (lower_band |=> oscillator_swing_reduce)
    else $error("swing reduce not set in lower band");
  expert_write_a: assert property (reg_wr && bank_sel == 2'h1 && reg_addr == 7'h31 |=>
    {phase_detector_pulse_widen, filter_settle_shortcut, charge_pump_current_sel} == $past(reg_wdata[6:0]))
    else $error("expert write not applied");
  reset_pump_a: assert property ($rose(rst_n) |-> charge_pump_current_sel == 5'h04)
    else $error("pump current reset value wrong");
  settle_short_a: assert property (transient && filter_settle_shortcut |=> !filter_settled ##[28:36] filter_settled)
    else $error("short settle delay wrong");
  settle_full_a: assert property (transient && !filter_settle_shortcut |=> !filter_settled[*8] ##[110:130] filter_settled)
    else $error("full settle delay wrong");
  cover property (iq_cal_start);
  cover property (transient && !filter_settle_shortcut);
  cover property (reg_rd && bank_sel == 2'h0);
endmodule

// ==== bench/tb_top.sv ====
// Bench for the extended receive status register bank.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, high_gain = 1'b0, search_done = 1'b0, status_read = 1'b0;
  logic rc_cal_busy = 1'b0, iq_cal_done = 1'b0, lower_band = 1'b0, transient = 1'b0;
  logic [1:0] rx_cmd = 2'h0;
  logic [3:0] chip_changes = 4'h0, rc_cal_res = 4'h0;
  logic [6:0] iq_cal_res = 7'h00, iq_val;
  logic [1:0] bank_sel;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, iq_cal_start, swing, widen, shortcut, filter_settled;
  logic [4:0] pump;
  int fail_count = 0;
  int checked = 0;
  // Clock of 40 ns period.
  always #20 clk = ~clk;
  rxecr_mcu_model u_mcu (.clk, .reg_rdata, .bank_sel, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
  rxecr_regs u_dut (.clk, .rst_n, .bank_sel, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .high_gain, .rx_cmd, .chip_changes, .search_done, .status_read, .rc_cal_busy, .rc_cal_res,
    .iq_cal_done, .iq_cal_res, .lower_band, .transient, .iq_cal_start, .quadrature_cal_value(iq_val),
    .oscillator_swing_reduce(swing), .phase_detector_pulse_widen(widen),
    .filter_settle_shortcut(shortcut), .charge_pump_current_sel(pump), .filter_settled);
  // Compares one value and counts it.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [1:0] bank, input logic [6:0] addr, input logic [7:0] exp);
    u_mcu.access(1'b1, bank, addr, 8'h00, d);
    check(d, exp);
  endtask
  task automatic wr(input logic [1:0] bank, input logic [6:0] addr, input logic [7:0] data);
    u_mcu.access(1'b0, bank, addr, data, d);
  endtask
  // Reset values and bank gating, unmapped offset included.
  task automatic t_bank();
    rd(2'h1, 7'h31, 8'h04);
    rd(2'h1, 7'h30, 8'h00);
    rd(2'h0, 7'h31, 8'h00);
    wr(2'h0, 7'h31, 8'h7f);
    rd(2'h1, 7'h31, 8'h04);
    rd(2'h1, 7'h2d, 8'h00);
  endtask
  // Snapshot of every receive sub-command, by event and by read.
  task automatic t_snapshot();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {high_gain, rx_cmd, chip_changes} <= {i[0], i[1:0], 4'(3 * i + 1)};
      @(posedge clk);
      {search_done, status_read} <= {!i[0], i[0]};
      @(posedge clk);
      {search_done, status_read} <= 2'b00;
      rd(2'h1, 7'h2e, {i[0], i[0], i[1:0], 4'(3 * i + 1)});
    end
    @(posedge clk);
    {search_done, status_read} <= 2'b11;
    @(posedge clk);
    {search_done, status_read} <= 2'b00;
    rd(2'h1, 7'h2e, 8'hfa);
  endtask
  // RC calibration flag and result.
  task automatic t_rc();
    @(posedge clk);
    {rc_cal_busy, rc_cal_res} <= {1'b1, 4'h9};
    rd(2'h1, 7'h2f, 8'h49);
    rc_cal_busy <= 1'b0;
    rd(2'h1, 7'h2f, 8'h09);
    rc_cal_res <= 4'h0;
  endtask
  // I/Q launch, completion, and software trim restore.
  task automatic t_iq();
    wr(2'h1, 7'h30, 8'h80);
    rd(2'h1, 7'h2f, 8'h80);
    rd(2'h1, 7'h30, 8'h80);
    wr(2'h1, 7'h30, 8'h11);
    rd(2'h1, 7'h30, 8'h80);
    {iq_cal_done, iq_cal_res} <= {1'b1, 7'h2a};
    @(posedge clk);
    iq_cal_done <= 1'b0;
    repeat (3) @(posedge clk);
    rd(2'h1, 7'h30, 8'h2a);
    check({1'b0, iq_val}, 8'h2a);
    rd(2'h1, 7'h2f, 8'h00);
    u_mcu.save_trim();
    wr(2'h1, 7'h30, 8'h00);
    u_mcu.restore_trim();
    rd(2'h1, 7'h30, 8'h2a);
    check({1'b0, iq_val}, 8'h2a);
  endtask
  // Expert controls, low band swing, and both settle delays.
  task automatic t_expert();
    wr(2'h1, 7'h31, 8'h65);
    rd(2'h1, 7'h31, 8'h65);
    check({1'b0, widen, shortcut, pump}, 8'h65);
    lower_band <= 1'b1;
    rd(2'h1, 7'h31, 8'he5);
    check({7'h00, swing}, 8'h01);
    lower_band <= 1'b0;
    for (int f = 0; f < 2; f++) begin
      @(posedge clk);
      transient <= 1'b1;
      @(posedge clk);
      transient <= 1'b0;
      repeat (f ? 100 : 20) @(negedge clk);
      check({7'h00, filter_settled}, 8'h00);
      repeat (40) @(negedge clk);
      check({7'h00, filter_settled}, 8'h01);
      u_mcu.expert_defaults();
    end
    wr(2'h1, 7'h31, 8'h80);
    rd(2'h1, 7'h31, 8'h80);
    check({7'h00, swing}, 8'h01);
    u_mcu.expert_defaults();
  endtask
  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (fail_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence after ten reset cycles.
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_bank();
    t_snapshot();
    t_rc();
    t_iq();
    t_expert();
    tally_and_finish();
  end
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule
bind rxecr_regs rxecr_assertions u_chk (.clk, .rst_n, .bank_sel, .reg_addr, .reg_wr, .reg_rd,
  .reg_wdata, .reg_rdata, .lower_band, .transient, .iq_cal_start, .oscillator_swing_reduce,
  .phase_detector_pulse_widen, .filter_settle_shortcut, .charge_pump_current_sel, .filter_settled);
